// ==== sem_pkg.sv ====
// constants, field positions and carrier types of the semaphore operation unit
// assumes a 32-bit APB register bus and four attached processors, two per pair
package sem_pkg;
  localparam int          NPROC        = 4;
  localparam int          ADDR_W       = 12;
  // register map: region in paddr[11:8]
  localparam logic [3:0]  REGION_CTX   = 4'h0;
  localparam logic [3:0]  REGION_TRIG  = 4'h1;
  localparam logic [3:0]  REGION_CINC  = 4'h2;
  // context region: processor in [5:4], word in [3:0]
  localparam int          CTX_PROC_LSB = 4;
  localparam logic [3:0]  OFS_CTX_LO   = 4'h0;
  localparam logic [3:0]  OFS_CTX_HI   = 4'h4;
  localparam logic [3:0]  OFS_OPADDR   = 4'h8;
  // trigger region: pair in [6], operation in [5:3], double word in [2]
  localparam int          PAIR_BIT     = 6;
  localparam int          TOP_LSB      = 3;
  localparam int          DWORD_BIT    = 2;
  // coherent increment region: processor in [3:2]
  localparam int          CINC_PROC_LSB = 2;
  // context bits: armed in low word, triggered is bit 62 = bit 30 of high word
  localparam int          ARMED_BIT    = 0;
  localparam int          TRIG_BIT     = 30;
  localparam logic        ARMED_RST    = 1'b0;
  localparam logic        TRIG_RST     = 1'b0;
  localparam logic [31:0] OPADDR_RST   = 32'h0000_0000;
  localparam logic [31:0] UNDEF_DATA   = 32'h0000_0000;
  // instruction fields
  localparam logic [5:0]  CINC_MAJOR   = 6'h01;
  localparam int          ALIGN_BITS   = 5;

  typedef enum logic [2:0] {
    MOP_FINC = 3'h0,
    MOP_FDEC = 3'h1,
    MOP_FCLR = 3'h2,
    MOP_NCRD = 3'h3,
    MOP_NCWR = 3'h4,
    MOP_CINC = 3'h5
  } mem_op_type;

  typedef struct packed {
    mem_op_type  op;
    logic        dword;
    logic        nocache;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic cached;
    logic priv;
    logic coherent;
  } lookup_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_WB   = 3'b011,
    ST_MEM  = 3'b010,
    ST_INV  = 3'b110,
    ST_DONE = 3'b100
  } state_type;
endpackage

// ==== sem_ctx_bank.sv ====
// per-processor armed, triggered and operation address state
// assumes one-hot write, launch and abort strobes from the same clock
`timescale 1ns/1ns
module sem_ctx_bank
  import sem_pkg::*;
#(
  parameter int N = 4
)(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // software writes
  input  wire logic [N-1:0]      wr_lo,
  input  wire logic [N-1:0]      wr_hi,
  input  wire logic [N-1:0]      wr_addr,
  input  wire logic [31:0]       wdata,
  // hardware events
  input  wire logic [N-1:0]      launch,
  input  wire logic [N-1:0]      load_addr,
  input  wire logic [31:0]       load_data,
  input  wire logic [N-1:0]      abort,
  // state
  output logic      [N-1:0]      armed,
  output logic      [N-1:0]      triggered,
  output logic      [N-1:0][31:0] op_addr
);
  if (N < 1) begin : g_bad
    $error("sem_ctx_bank needs at least one processor");
  end

  for (genvar p = 0; p < N; p++) begin : g_proc
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        armed[p] <= ARMED_RST;
      else if (abort[p] || launch[p])
        armed[p] <= 1'b0;
      else if (wr_lo[p])
        armed[p] <= wdata[ARMED_BIT];
    end
    // launch beats a software clear of the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        triggered[p] <= TRIG_RST;
      else if (launch[p])
        triggered[p] <= 1'b1;
      else if (wr_lo[p])
        triggered[p] <= 1'b0;
      else if (wr_hi[p])
        triggered[p] <= wdata[TRIG_BIT];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        op_addr[p] <= OPADDR_RST;
      else if (load_addr[p])
        op_addr[p] <= load_data;
      else if (wr_addr[p])
        op_addr[p] <= wdata;
    end

    property p_abort;
      @(posedge pclk) disable iff (!presetn)
      abort[p] |=> !armed[p];
    endproperty
    a_abort: assert property (p_abort)
      else $error("armed survived an interrupt");
  end
endmodule

// ==== sem_cinc_decode.sv ====
// recognises the coherent increment instruction and raises its two exceptions
// assumes translation and rights results arrive with the instruction
`timescale 1ns/1ns
module sem_cinc_decode
  import sem_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // instruction in
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_base,
  input  wire logic        psw_translate,
  input  wire logic [31:0] tlb_phys,
  input  wire logic        tlb_hit,
  input  wire logic        rights_read,
  input  wire logic        rights_write,
  input  wire logic        instr_spec,
  output logic             instr_ready,
  output logic             miss_fault,
  output logic             rights_trap,
  // pending request to the sequencer
  input  wire logic        take,
  output logic             pend,
  output logic [31:0]      pend_addr
);
  logic accept;
  logic is_cinc;
  logic fault;
  logic trap;

  assign accept = instr_valid && instr_ready;
  assign is_cinc = instr_word[31:26] == CINC_MAJOR && instr_word[4:0] == 5'h00;
  // only miss fault and rights trap
  assign fault = psw_translate && !tlb_hit;
  assign trap  = !fault && !(rights_read && rights_write);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend        <= 1'b0;
      pend_addr   <= 32'h0000_0000;
      miss_fault  <= 1'b0;
      rights_trap <= 1'b0;
    end
    else
    begin
      miss_fault  <= accept && is_cinc && !instr_spec && fault;
      rights_trap <= accept && is_cinc && !instr_spec && trap;
      if (accept && is_cinc && !instr_spec && !fault && !trap)
      begin
        pend <= 1'b1;
        pend_addr <= psw_translate ? tlb_phys : instr_base;
      end
      else if (take)
        pend <= 1'b0;
    end
  end

  // a new instruction waits while one is pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_ready <= 1'b0;
    else
      instr_ready <= !(pend && !take) && !accept;
  end

  property p_spec;
    @(posedge pclk) disable iff (!presetn)
    accept && instr_spec |=> !miss_fault && !rights_trap && pend == $past(pend && !take);
  endproperty
  a_spec: assert property (p_spec)
    else $error("speculative instruction acted on");
endmodule

// ==== sem_op_unit.sv ====
// semaphore operation unit of the processor agent: APB slave, trigger decode,
// memory sequencer. assumes a coherence lookup answering in the same cycle.
// Contract
// - coherent increment adds one to the addressed double word
// - privately held line is written back before the increment
// - read copies in other nodes' coherence caches may stay
// - after the increment every holder invalidates its data cache line
// - flush encoding with zero five-bit immediate means coherent increment
// - instruction checks read and write rights, never speculative
// - translation-enable bit picks virtual or absolute address
// - only a translation miss fault or a rights trap
// - interrupt or miss disarms; software retries while triggered is zero
// - six fetch addresses, three per pair: increment, decrement, clear
// - armed fetch read launches, disarms and sets triggered
// - unarmed trigger access returns junk and changes no bits
// - access size picks word or double word operation
// - one noncoherent read and one write address per pair
// - armed noncoherent access uses operation address, disarms, triggers
// - unarmed noncoherent write is dropped without memory access
// - four coherent increment addresses, one per processor
// - armed increment write loads address from data, disarms, triggers
// - uncacheable noncoherent lines never enter a data cache
// - noncoherent operation on a cached line returns an error
// - mixing coherent and noncoherent use of a line returns an error
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module sem_op_unit
  import sem_pkg::*;
#(
  parameter int NP = NPROC
)(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [1:0]        req_proc,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sequence breakers
  input  wire logic [NP-1:0]     ext_intr,
  input  wire logic [NP-1:0]     tlb_miss,
  // instruction path
  input  wire logic              instr_valid,
  input  wire logic [31:0]       instr_word,
  input  wire logic [31:0]       instr_base,
  input  wire logic              psw_translate,
  input  wire logic [31:0]       tlb_phys,
  input  wire logic              tlb_hit,
  input  wire logic              rights_read,
  input  wire logic              rights_write,
  input  wire logic              instr_spec,
  output logic                   instr_ready,
  output logic                   instr_miss_fault,
  output logic                   instr_rights_trap,
  output logic                   instr_done,
  output logic                   instr_err,
  // coherence lookup
  output logic      [31:0]       lookup_addr,
  input  wire lookup_type        lookup,
  // memory and coherence system
  output logic                   wb_valid,
  input  wire logic              wb_ack,
  output mem_req_type            mem_req,
  output logic                   mem_valid,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_err,
  output logic                   inval_valid,
  output logic      [31:0]       inval_addr
);
  if (NP != 4) begin : g_bad
    $error("sem_op_unit decodes exactly four processors");
  end

  state_type          state;
  logic               src_apb;
  logic               err;
  logic [31:0]        rdata;
  logic               apb_take;
  logic [3:0]         region;
  logic [1:0]         ctx_proc;
  logic [2:0]         top_idx;
  logic               trig_ok;
  logic               cinc_ok;
  logic               fire;
  logic               take_instr;
  logic               lk_err;
  logic               is_nc;
  logic               dec_pend;
  logic [31:0]        dec_addr;
  logic [NP-1:0]      wr_lo;
  logic [NP-1:0]      wr_hi;
  logic [NP-1:0]      wr_addr;
  logic [NP-1:0]      launch;
  logic [NP-1:0]      load_addr;
  logic [NP-1:0]      armed;
  logic [NP-1:0]      triggered;
  logic [NP-1:0][31:0] op_addr;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign apb_take = psel && penable && !pready && state == ST_IDLE;
  assign region   = paddr[11:8];
  assign ctx_proc = paddr[CTX_PROC_LSB+1:CTX_PROC_LSB];
  assign top_idx  = paddr[TOP_LSB+2:TOP_LSB];
  // fetch and noncoherent reads, noncoherent write, per pair
  assign trig_ok = region == REGION_TRIG && paddr[PAIR_BIT] == req_proc[1]
                   && ((top_idx <= 3'(MOP_NCRD) && !pwrite)
                       || (top_idx == 3'(MOP_NCWR) && pwrite));
  assign cinc_ok = region == REGION_CINC && pwrite
                   && paddr[CINC_PROC_LSB+1:CINC_PROC_LSB] == req_proc;
  assign fire       = apb_take && (trig_ok || cinc_ok) && armed[req_proc];
  assign take_instr = state == ST_IDLE && !(psel && penable && !pready) && dec_pend;
  assign is_nc      = mem_req.op != MOP_CINC;
  // noncoherent on a cached line fails
  assign lk_err = is_nc ? (lookup.cached || lookup.coherent) : !lookup.coherent;

  always_comb
  begin
    wr_lo     = '0;
    wr_hi     = '0;
    wr_addr   = '0;
    launch    = '0;
    load_addr = '0;
    if (apb_take && pwrite && region == REGION_CTX)
    begin
      wr_lo[ctx_proc]   = paddr[3:0] == OFS_CTX_LO;
      wr_hi[ctx_proc]   = paddr[3:0] == OFS_CTX_HI;
      wr_addr[ctx_proc] = paddr[3:0] == OFS_OPADDR;
    end
    if (fire)
      launch[req_proc] = 1'b1;
    // increment address comes from store data
    if (fire && cinc_ok)
      load_addr[req_proc] = 1'b1;
  end

  sem_ctx_bank #(
    .N         (NP)
  ) u_bank (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_lo     (wr_lo),
    .wr_hi     (wr_hi),
    .wr_addr   (wr_addr),
    .wdata     (pwdata),
    .launch    (launch),
    .load_addr (load_addr),
    .load_data (pwdata),
    .abort     (ext_intr | tlb_miss),
    .armed     (armed),
    .triggered (triggered),
    .op_addr   (op_addr)
  );

  sem_cinc_decode u_dec (
    .pclk          (pclk),
    .presetn       (presetn),
    .instr_valid   (instr_valid),
    .instr_word    (instr_word),
    .instr_base    (instr_base),
    .psw_translate (psw_translate),
    .tlb_phys      (tlb_phys),
    .tlb_hit       (tlb_hit),
    .rights_read   (rights_read),
    .rights_write  (rights_write),
    .instr_spec    (instr_spec),
    .instr_ready   (instr_ready),
    .miss_fault    (instr_miss_fault),
    .rights_trap   (instr_rights_trap),
    .take          (take_instr),
    .pend          (dec_pend),
    .pend_addr     (dec_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= ST_IDLE;
      src_apb     <= 1'b0;
      err         <= 1'b0;
      rdata       <= 32'h0000_0000;
      mem_req     <= '0;
      lookup_addr <= 32'h0000_0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          err <= 1'b0;
          if (fire)
          begin
            state   <= ST_LOOK;
            src_apb <= 1'b1;
            mem_req.op <= cinc_ok ? MOP_CINC : mem_op_type'(top_idx);
            mem_req.dword <= cinc_ok || paddr[DWORD_BIT];
            // keep noncoherent lines out of caches
            mem_req.nocache <= !cinc_ok;
            mem_req.addr  <= cinc_ok ? pwdata : op_addr[req_proc];
            mem_req.wdata <= pwdata;
            lookup_addr   <= cinc_ok ? pwdata : op_addr[req_proc];
          end
          else if (take_instr)
          begin
            state   <= ST_LOOK;
            src_apb <= 1'b0;
            mem_req.op      <= MOP_CINC;
            mem_req.dword   <= 1'b1;
            mem_req.nocache <= 1'b0;
            mem_req.addr  <= dec_addr;
            mem_req.wdata <= 32'h0000_0000;
            lookup_addr   <= dec_addr;
          end
        end
        ST_LOOK:
        begin
          if (lk_err)
          begin
            err   <= 1'b1;
            state <= ST_DONE;
          end
          // write back a private line first
          else if (!is_nc && lookup.priv)
            state <= ST_WB;
          else
            state <= ST_MEM;
        end
        ST_WB:
          if (wb_ack)
            state <= ST_MEM;
        ST_MEM:
          if (mem_ack)
          begin
            rdata <= mem_rdata;
            err   <= mem_err;
            // increment done at memory, then invalidate
            state <= (!is_nc && !mem_err) ? ST_INV : ST_DONE;
          end
        ST_INV:
          state <= ST_DONE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // memory handshakes held until acknowledged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wb_valid  <= 1'b0;
      mem_valid <= 1'b0;
    end
    else
    begin
      wb_valid  <= (state == ST_LOOK && !lk_err && !is_nc && lookup.priv)
                   || (wb_valid && !wb_ack);
      mem_valid <= (state == ST_LOOK && !lk_err && !(!is_nc && lookup.priv))
                   || (state == ST_WB && wb_ack) || (mem_valid && !mem_ack);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inval_valid <= 1'b0;
      inval_addr  <= 32'h0000_0000;
    end
    else
    begin
      inval_valid <= state == ST_MEM && mem_ack && !is_nc && !mem_err;
      if (state == ST_MEM && mem_ack)
        inval_addr <= mem_req.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      instr_done <= 1'b0;
      instr_err  <= 1'b0;
    end
    else
    begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      instr_done <= 1'b0;
      instr_err  <= 1'b0;
      if (state == ST_DONE && src_apb)
      begin
        pready  <= 1'b1;
        pslverr <= err;
        prdata  <= (mem_req.op == MOP_NCWR || mem_req.op == MOP_CINC) ? UNDEF_DATA : rdata;
      end
      else if (state == ST_DONE)
      begin
        instr_done <= 1'b1;
        instr_err  <= err;
      end
      else if (apb_take && !fire)
      begin
        pready <= 1'b1;
        prdata <= UNDEF_DATA;
        if (region == REGION_CTX && !pwrite)
        begin
          if (paddr[3:0] == OFS_CTX_LO)
            prdata <= 32'(armed[ctx_proc]) << ARMED_BIT;
          else if (paddr[3:0] == OFS_CTX_HI)
            prdata <= 32'(triggered[ctx_proc]) << TRIG_BIT;
          else if (paddr[3:0] == OFS_OPADDR)
            prdata <= op_addr[ctx_proc];
          else
            pslverr <= 1'b1;
        end
        else if (region == REGION_CTX)
          pslverr <= !(paddr[3:0] == OFS_CTX_LO || paddr[3:0] == OFS_CTX_HI
                       || paddr[3:0] == OFS_OPADDR);
        else if (!(trig_ok || cinc_ok))
          pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_launch;
    @(posedge pclk) disable iff (!presetn)
    fire && trig_ok |=> !armed[$past(req_proc)] && triggered[$past(req_proc)] && state == ST_LOOK;
  endproperty
  a_launch: assert property (p_launch)
    else $error("fetch launch did not swap armed for triggered");

  property p_unarmed;
    @(posedge pclk) disable iff (!presetn)
    apb_take && (trig_ok || cinc_ok) && !armed[req_proc] && !ext_intr[req_proc]
      && !tlb_miss[req_proc]
      |=> pready && triggered[$past(req_proc)] == $past(triggered[req_proc])
          && !armed[$past(req_proc)];
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("unarmed trigger changed state or stalled");

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
    apb_take && pwrite && trig_ok && !armed[req_proc] && !dec_pend |=> !mem_valid [*4];
  endproperty
  a_drop: assert property (p_drop)
    else $error("unarmed noncoherent write reached memory");

  property p_cinc_addr;
    @(posedge pclk) disable iff (!presetn)
    fire && cinc_ok |=> op_addr[$past(req_proc)] == $past(pwdata) && mem_req.op == MOP_CINC;
  endproperty
  a_cinc_addr: assert property (p_cinc_addr)
    else $error("increment address not copied from store data");

  property p_wb_first;
    @(posedge pclk) disable iff (!presetn)
    state == ST_LOOK && !lk_err && !is_nc && lookup.priv |=> wb_valid && !mem_valid;
  endproperty
  a_wb_first: assert property (p_wb_first)
    else $error("private line not written back first");

  property p_inval;
    @(posedge pclk) disable iff (!presetn)
    state == ST_MEM && mem_ack && !is_nc && !mem_err |=> inval_valid ##1 !inval_valid;
  endproperty
  a_inval: assert property (p_inval)
    else $error("no invalidate after coherent increment");

  property p_nc_cached;
    @(posedge pclk) disable iff (!presetn)
    state == ST_LOOK && is_nc && lookup.cached |=> !mem_valid ##1 (pslverr || instr_err);
  endproperty
  a_nc_cached: assert property (p_nc_cached)
    else $error("noncoherent op on cached line not failed");

  property p_mix;
    @(posedge pclk) disable iff (!presetn)
    state == ST_LOOK && !is_nc && !lookup.coherent |-> ##2 (pslverr || instr_err);
  endproperty
  a_mix: assert property (p_mix)
    else $error("mixed access not reported");

  property p_nocache;
    @(posedge pclk) disable iff (!presetn)
    mem_valid |-> mem_req.nocache == is_nc;
  endproperty
  a_nocache: assert property (p_nocache)
    else $error("cacheability hint wrong");

  c_fetch: cover property (@(posedge pclk) disable iff (!presetn)
    fire && trig_ok && !pwrite ##[1:20] pready);
  c_cinc_wb: cover property (@(posedge pclk) disable iff (!presetn)
    wb_valid ##[1:20] inval_valid);
  c_instr: cover property (@(posedge pclk) disable iff (!presetn)
    take_instr ##[1:20] instr_done);
endmodule

// ==== sem_mem_model.sv ====
// memory and coherence system model for the semaphore operation unit
// assumes requests stay held until acknowledged at a clock edge
`timescale 1ns/1ns
module sem_mem_model
  import sem_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request side
  input  wire mem_req_type mem_req,
  input  wire logic        mem_valid,
  input  wire logic        wb_valid,
  // answer side
  output logic             mem_ack,
  output logic             wb_ack,
  output logic [31:0]      mem_rdata,
  output logic             mem_err,
  output mem_req_type      last_req,
  output int               n_req
);
  logic [1:0] wait_cnt;
  assign wb_ack  = wb_valid;
  assign mem_err = 1'b0;
  // slow on purpose: ack on the third held cycle; data toggles when not answering
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_cnt <= '0; mem_ack <= 1'b0; mem_rdata <= '0; last_req <= '0; n_req <= 0;
    end
    else if (mem_valid && !mem_ack && wait_cnt == 2'h2)
    begin
      mem_ack <= 1'b1; mem_rdata <= mem_req.addr + 32'h1; last_req <= mem_req;
      n_req <= n_req + 1; wait_cnt <= '0;
    end
    else
    begin
      mem_ack <= 1'b0; mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem_valid && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
endmodule

// ==== sem_op_unit_test.sv ====
// self-checking bench for the semaphore operation unit
// assumes the memory model beside it answers every request
`timescale 1ns/1ns
module sem_op_unit_test;
  import sem_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        instr_valid, psw_translate, instr_ready, instr_miss_fault, instr_done, instr_err;
  logic        mem_valid, mem_ack, wb_valid, wb_ack, mem_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_rdata, instr_word, instr_base, inval_addr;
  logic [1:0]  req_proc;
  logic [3:0]  ext_intr, tlb_miss;
  lookup_type  lookup;
  mem_req_type mem_req, last_req;
  int          n_req, n0, err_count, checks_done;
  sem_op_unit i_sem_op_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .req_proc, .prdata, .pready, .pslverr, .ext_intr, .tlb_miss, .instr_valid, .instr_word,
    .instr_base, .psw_translate, .tlb_phys(32'h0), .tlb_hit(1'b0), .rights_read(1'b1),
    .rights_write(1'b1), .instr_spec(1'b0), .instr_ready, .instr_miss_fault,
    .instr_rights_trap(), .instr_done, .instr_err,
    .lookup_addr(), .lookup, .wb_valid, .wb_ack, .mem_req, .mem_valid, .mem_ack, .mem_rdata,
    .mem_err, .inval_valid(), .inval_addr);
  sem_mem_model i_sem_mem_model (.pclk, .presetn, .mem_req, .mem_valid, .wb_valid, .mem_ack,
    .wb_ack, .mem_rdata, .mem_err, .last_req, .n_req);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one apb transfer, waits for pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n >= 40)
    begin
      err_count++;
      test_done();
    end
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic arm(input int p);
    apb(1'b1, 12'(p * 16), 32'h1);
  endtask
  task automatic ctx(input int p, input logic a, input logic t);
    apb(1'b0, 12'(p * 16), 32'h0);
    chk({31'h0, rd[ARMED_BIT]}, {31'h0, a}, "armed bit");
    apb(1'b0, 12'(p * 16 + 4), 32'h0);
    chk({31'h0, rd[TRIG_BIT]}, {31'h0, t}, "triggered bit");
  endtask
  task automatic t_arm();
    arm(1);
    ctx(1, 1'b1, 1'b0);
    ctx(0, 1'b0, 1'b0);
    $display("done arm");
  endtask
  task automatic t_fetch();
    req_proc <= 2'h0; lookup <= '0;
    for (int op = 0; op < 4; op++)
    begin
      arm(0);
      apb(1'b1, 12'h008, 32'h40 + 32'(op * 8));
      apb(1'b0, 12'(12'h100 + op * 8 + op % 2 * 4), 32'h0);
      chk(rd, 32'h41 + 32'(op * 8), "fetch data");
      chk({29'h0, last_req.op}, 32'(op), "fetch kind");
      chk({31'h0, last_req.dword}, 32'(op % 2), "size");
      ctx(0, 1'b0, 1'b1);
    end
    arm(0); lookup <= 3'b100;
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1, "cached line");
    $display("done fetch");
  endtask
  task automatic t_unarmed();
    n0 = n_req;
    apb(1'b0, 12'h110, 32'h0);
    chk(rd, UNDEF_DATA, "unarmed read");
    chk({31'h0, e}, 32'h0, "unarmed no error");
    apb(1'b1, 12'h120, 32'h5);
    chk(32'(n_req - n0), 32'h0, "memory untouched");
    ctx(0, 1'b0, 1'b1);
    $display("done unarmed");
  endtask
  task automatic t_cinc();
    req_proc <= 2'h3; lookup <= 3'b001;
    arm(3);
    apb(1'b1, 12'h20c, 32'h1000);
    chk({29'h0, last_req.op}, 32'(MOP_CINC), "increment kind");
    chk(last_req.addr, 32'h1000, "increment address");
    apb(1'b0, 12'h038, 32'h0);
    chk(rd, 32'h1000, "address copied");
    ctx(3, 1'b0, 1'b1);
    apb(1'b1, 12'h200, 32'h1000);
    chk({31'h0, e}, 32'h1, "foreign address");
    arm(3); lookup <= 3'b000;
    apb(1'b1, 12'h20c, 32'h1000);
    chk({31'h0, e}, 32'h1, "noncoherent line");
    $display("done cinc");
  endtask
  task automatic t_intr();
    req_proc <= 2'h2;
    for (int k = 0; k < 2; k++)
    begin
      arm(2);
      if (k == 0) ext_intr <= 4'h4; else tlb_miss <= 4'h4;
      @(posedge pclk);
      ext_intr <= 4'h0; tlb_miss <= 4'h0;
      ctx(2, 1'b0, 1'b0);
    end
    $display("done interrupt");
  endtask
  task automatic t_instr();
    n0 = n_req; lookup <= 3'b011;
    chk({31'h0, instr_ready}, 32'h1, "ready when idle");
    instr_word <= 32'h0400_0000; instr_base <= 32'h2000; instr_valid <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    for (int n = 0; n < 40 && instr_done !== 1'b1; n++)
      @(posedge pclk);
    chk({31'h0, instr_done}, 32'h1, "instruction done");
    chk({31'h0, instr_err}, 32'h0, "instruction error");
    chk(32'(n_req - n0), 32'h1, "one increment");
    chk({29'h0, last_req.op}, 32'(MOP_CINC), "instruction kind");
    chk(last_req.addr, 32'h2000, "absolute address");
    chk(inval_addr, 32'h2000, "invalidate address");
    psw_translate <= 1'b1; instr_valid <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    @(posedge pclk);
    chk({31'h0, instr_miss_fault}, 32'h1, "translation miss");
    psw_translate <= 1'b0;
    $display("done instr");
  endtask
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    req_proc = '0; ext_intr = '0; lookup = '0; err_count = 0; checks_done = 0;
    tlb_miss = '0; instr_valid = 1'b0; psw_translate = 1'b0; instr_word = '0; instr_base = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_arm();
    t_fetch();
    t_unarmed();
    t_cinc();
    t_intr();
    t_instr();
    test_done();
  end
endmodule
